// ---- src/mcp_protect.sv ----
`timescale 1ns/1ps
module mcp_protect
    import mcp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned MAX_STARTS = 5
) (
    input wire logic mclk_i, // 10 MHz system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic s_axi_awvalid_i, // write address valid
    output logic s_axi_awready_o, // write address ready
    input wire logic [7:0] s_axi_awaddr_i, // write byte address
    input wire logic s_axi_wvalid_i, // write data valid
    output logic s_axi_wready_o, // write data ready
    input wire logic [31:0] s_axi_wdata_i, // write data
    input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
    output logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    output logic [1:0] s_axi_bresp_o, // write response code
    input wire logic s_axi_arvalid_i, // read address valid
    output logic s_axi_arready_o, // read address ready
    input wire logic [7:0] s_axi_araddr_i, // read byte address
    output logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i, // read data ready
    output logic [31:0] s_axi_rdata_o, // read data
    output logic [1:0] s_axi_rresp_o, // read response code
    input wire logic [15:0] ia_i, // phase a current, 0.1 A
    input wire logic [15:0] ib_i, // phase b current, 0.1 A
    input wire logic [15:0] ic_i, // phase c current, 0.1 A
    input wire logic [15:0] neg_seq_i, // negative sequence current, 0.1 A
    input wire logic [15:0] pos_seq_i, // positive sequence current, 0.1 A
    input wire logic [15:0] gnd_sec_i, // ground ct secondary current, mA
    input wire logic [7:0] thermal_used_i, // thermal capacity used, percent
    input wire logic [2:0] nv_starts_i, // saved start count from storage
    output logic [2:0] nv_starts_o, // start count to storage
    output logic [15:0] ub_bias_o, // unbalance ratio to thermal memory, percent
    output logic motor_running_o, // motor in running state
    output logic accel_trip_o, // acceleration time fault
    output logic overload_trip_o, // thermal capacity exceeded
    output logic starts_trip_o, // starts per hour trip
    output logic ub_trip_o, // unbalance trip
    output logic ub_alarm_o, // unbalance alarm
    output logic single_phase_trip_o, // single phase trip
    output logic gf_trip_o, // ground fault trip
    output logic gf_alarm_o, // ground fault alarm
    output logic uc_alarm_o, // undercurrent alarm
    output logic jam_trip_o // mechanical jam trip
);
    localparam int unsigned NTMR = 8;
    localparam int unsigned T_ACCEL = 0;
    localparam int unsigned T_UBT = 1;
    localparam int unsigned T_UBA = 2;
    localparam int unsigned T_SP = 3;
    localparam int unsigned T_GFT = 4;
    localparam int unsigned T_GFA = 5;
    localparam int unsigned T_UC = 6;
    localparam int unsigned T_JAM = 7;

    if (TICK_CYCLES < 1 || TICK_CYCLES > 1_048_576) begin : g_chk_tick
        $error("TICK_CYCLES must be 1 to 2^20");
    end
    if (MAX_STARTS < 1 || MAX_STARTS > 7) begin : g_chk_starts
        $error("MAX_STARTS must be 1 to 7");
    end

    typedef struct packed {
        logic [NCFG-1:0][31:0] cfg;
        mcp_motor_e motor;
        logic [NTMR-1:0][15:0] tmr;
        logic [19:0] div;
        logic [9:0] mdiv;
        logic [MAX_STARTS-1:0][5:0] age;
        logic restored;
        logic [NFLAG-1:0] flags;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mcp_state_s;

    mcp_state_s st_reg;
    mcp_state_s st_next;

    // restarts whenever the condition drops, saturates instead of wrapping
    function automatic logic [15:0] timer_step(input logic [15:0] cnt, input logic cond, input logic tick);
        if (!cond) begin
            return 16'h0000;
        end
        if (tick && cnt != 16'hffff) begin
            return cnt + 16'h0001;
        end
        return cnt;
    endfunction : timer_step

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction : apply_strb

    function automatic logic [2:0] count_starts(input logic [MAX_STARTS-1:0][5:0] ages);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < MAX_STARTS; i++) begin
            if (ages[i] != 6'h00) begin
                n = n + 3'h1;
            end
        end
        return n;
    endfunction : count_starts

    // derived measurements
    logic [17:0] phase_sum;
    logic [31:0] avg;
    logic [31:0] rated;
    logic above_full;
    logic below_full;
    logic stop_cond;
    logic [31:0] ratio_full;
    logic [15:0] ub_ratio;
    logic [31:0] gnd_amps;
    logic [2:0] start_cnt;
    logic [2:0] start_lim;

    assign phase_sum = {2'b00, ia_i} + {2'b00, ib_i} + {2'b00, ic_i};
    assign avg = 32'(phase_sum / 18'd3);
    assign rated = {16'h0000, st_reg.cfg[IDX_RATED][15:0]};
    assign above_full = avg > rated;
    assign below_full = avg < rated;
    // ct primary is in amps, currents in tenths
    assign stop_cond = avg * FULL_PCT < {16'h0000, st_reg.cfg[IDX_CT_PRI][15:0]} * 32'h0000_000a * STOP_PCT;
    always_comb begin
        ratio_full = 32'h0000_0000;
        if (above_full) begin
            if (pos_seq_i != 16'h0000) begin
                ratio_full = {16'h0000, neg_seq_i} * FULL_PCT / {16'h0000, pos_seq_i};
            end
        end else if (rated != 32'h0000_0000) begin
            ratio_full = {16'h0000, neg_seq_i} * FULL_PCT / rated;
        end
    end
    assign ub_ratio = (ratio_full > 32'h0000_ffff) ? 16'hffff : ratio_full[15:0];
    always_comb begin
        // illegal ratio codes fall back to 2000:1
        if (st_reg.cfg[IDX_GF_CT][2:0] == GF_CT_2000 || st_reg.cfg[IDX_GF_CT][2:0] > GF_CT_MAX) begin
            gnd_amps = {16'h0000, gnd_sec_i} * GF_2000_MUL;
        end else begin
            gnd_amps = {16'h0000, gnd_sec_i} * {29'h0, st_reg.cfg[IDX_GF_CT][2:0]} / GF_X5_DIV;
        end
    end
    assign start_cnt = count_starts(st_reg.age);
    assign start_lim = st_reg.cfg[IDX_CTRL][CTRL_LIM_LSB +: 3];

    always_comb begin
        logic tick;
        logic minute;
        logic do_start;
        logic placed;
        logic motor_on;
        logic [15:0] lvl;
        logic [15:0] dly;
        logic [NFLAG-1:0] fire;
        logic [NTMR-1:0] cond;
        logic [5:0] widx;
        logic clr;
        logic [NFLAG-1:0] latched;
        tick = 1'b0;
        minute = 1'b0;
        do_start = 1'b0;
        placed = 1'b0;
        fire = '0;
        cond = '0;
        clr = 1'b0;
        latched = '0;
        lvl = 16'h0000;
        dly = 16'h0000;
        widx = st_reg.waddr[7:2];
        motor_on = st_reg.motor != MCP_STOPPED;
        st_next = st_reg;

        // 0.1 s tick and minute enable
        if (st_reg.div == 20'(TICK_CYCLES - 1)) begin
            st_next.div = 20'h00000;
            tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 20'h00001;
        end
        if (tick) begin
            if (st_reg.mdiv == MIN_TICKS - 10'h001) begin
                st_next.mdiv = 10'h000;
                minute = 1'b1;
            end else begin
                st_next.mdiv = st_reg.mdiv + 10'h001;
            end
        end

        // motor state
        unique case (st_reg.motor)
            MCP_STOPPED: begin
                if (above_full) begin
                    st_next.motor = MCP_STARTING;
                    do_start = 1'b1;
                end
            end
            MCP_STARTING: begin
                if (stop_cond) begin
                    st_next.motor = MCP_STOPPED;
                end else if (below_full) begin
                    st_next.motor = MCP_RUNNING;
                end
            end
            MCP_RUNNING: begin
                if (stop_cond) begin
                    st_next.motor = MCP_STOPPED;
                end
            end
        endcase

        // sliding hour: each start holds a slot for sixty minutes
        for (int i = 0; i < MAX_STARTS; i++) begin
            if (minute && st_reg.age[i] != 6'h00) begin
                st_next.age[i] = st_reg.age[i] - 6'h01;
            end
        end
        if (!st_reg.restored) begin
            st_next.restored = 1'b1;
            for (int i = 0; i < MAX_STARTS; i++) begin
                st_next.age[i] = (3'(i) < nv_starts_i) ? HOUR_MIN : 6'h00;
            end
        end else if (do_start) begin
            for (int i = 0; i < MAX_STARTS; i++) begin
                if (!placed && st_reg.age[i] == 6'h00) begin
                    st_next.age[i] = HOUR_MIN;
                    placed = 1'b1;
                end
            end
        end

        // persistence conditions
        cond[T_ACCEL] = st_reg.motor == MCP_STARTING && st_reg.cfg[IDX_ACCEL][15:0] != 16'h0000;
        lvl = st_reg.cfg[IDX_UB_TRIP][LVL_LSB +: 16];
        cond[T_UBT] = motor_on && lvl != 16'h0000 && ub_ratio > lvl;
        cond[T_SP] = lvl != 16'h0000 && motor_on &&
            ((above_full && {16'h0000, ub_ratio} > SP_UB_PCT) ||
             (!above_full && avg * FULL_PCT > rated * SP_LOAD_PCT &&
              (ia_i == 16'h0000 || ib_i == 16'h0000 || ic_i == 16'h0000)));
        lvl = st_reg.cfg[IDX_UB_ALM][LVL_LSB +: 16];
        cond[T_UBA] = motor_on && lvl != 16'h0000 && ub_ratio > lvl;
        lvl = st_reg.cfg[IDX_GF_TRIP][LVL_LSB +: 16];
        cond[T_GFT] = lvl != 16'h0000 && gnd_amps > {16'h0000, lvl};
        lvl = st_reg.cfg[IDX_GF_ALM][LVL_LSB +: 16];
        cond[T_GFA] = lvl != 16'h0000 && gnd_amps > {16'h0000, lvl};
        lvl = st_reg.cfg[IDX_UC][LVL_LSB +: 16];
        cond[T_UC] = motor_on && lvl != 16'h0000 && avg < {16'h0000, lvl};
        lvl = st_reg.cfg[IDX_JAM][LVL_LSB +: 16];
        // out-of-range jam levels act as OFF
        cond[T_JAM] = st_reg.motor == MCP_RUNNING && lvl >= JAM_PCT_MIN && lvl <= JAM_PCT_MAX &&
                      avg * FULL_PCT > rated * {16'h0000, lvl};
        for (int t = 0; t < NTMR; t++) begin
            st_next.tmr[t] = timer_step(st_reg.tmr[t], cond[t], tick);
        end

        // delays in 0.1 s ticks; zero delay fires at once, except jam (5 ticks minimum) and accel (zero is off)
        fire[F_ACCEL] = cond[T_ACCEL] && st_reg.tmr[T_ACCEL] >= st_reg.cfg[IDX_ACCEL][15:0];
        fire[F_OL] = thermal_used_i >= THERM_FULL;
        fire[F_STARTS] = start_lim != 3'h0 && start_cnt >= start_lim && st_reg.motor == MCP_STOPPED;
        fire[F_UBT] = cond[T_UBT] && st_reg.tmr[T_UBT] >= st_reg.cfg[IDX_UB_TRIP][DLY_LSB +: 16];
        fire[F_UBA] = cond[T_UBA] && st_reg.tmr[T_UBA] >= st_reg.cfg[IDX_UB_ALM][DLY_LSB +: 16];
        fire[F_SP] = cond[T_SP] && st_reg.tmr[T_SP] > SP_TICKS;
        dly = st_reg.cfg[IDX_GF_TRIP][DLY_LSB +: 16];
        dly = (dly > GF_DLY_MAX) ? GF_DLY_MAX : dly;
        fire[F_GFT] = cond[T_GFT] && st_reg.tmr[T_GFT] >= dly;
        fire[F_GFA] = cond[T_GFA] && st_reg.tmr[T_GFA] >= st_reg.cfg[IDX_GF_ALM][DLY_LSB +: 16];
        fire[F_UC] = cond[T_UC] && st_reg.tmr[T_UC] >= st_reg.cfg[IDX_UC][DLY_LSB +: 16];
        dly = st_reg.cfg[IDX_JAM][DLY_LSB +: 16];
        dly = (dly < JAM_DLY_MIN) ? JAM_DLY_MIN : ((dly > JAM_DLY_MAX) ? JAM_DLY_MAX : dly);
        fire[F_JAM] = cond[T_JAM] && st_reg.tmr[T_JAM] >= dly;

        // axi write: address and data taken in either order
        if (s_axi_awvalid_i && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.waddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata_i;
            st_next.wstrb = s_axi_wstrb_i;
        end
        if (st_reg.bvalid && s_axi_bready_i) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            if (widx < 6'(NCFG)) begin
                st_next.cfg[widx] = apply_strb(st_reg.cfg[widx], st_reg.wdata, st_reg.wstrb) & CFG_MASK[widx];
            end else if (widx == IDX_CLEAR) begin
                clr = st_reg.wstrb[0] && st_reg.wdata[CLEAR_BIT];
            end else if (widx != IDX_STATUS && widx != IDX_UB_RATIO) begin
                st_next.bresp = RESP_SLVERR;
            end
        end

        // sticky trips; a new fault in the clear cycle wins
        latched[F_ACCEL] = 1'b1;
        latched[F_OL] = 1'b1;
        latched[F_STARTS] = 1'b1;
        latched[F_UBT] = 1'b1;
        latched[F_SP] = 1'b1;
        latched[F_GFT] = 1'b1;
        latched[F_JAM] = 1'b1;
        latched[F_UC] = st_reg.cfg[IDX_CTRL][CTRL_UC_LATCH_BIT];
        for (int f = 0; f < NFLAG; f++) begin
            if (latched[f]) begin
                st_next.flags[f] = fire[f] || (st_reg.flags[f] && !clr);
            end else begin
                st_next.flags[f] = fire[f];
            end
        end
        // with CTRL auto set, lockout ends when the oldest start leaves the hour
        if (st_reg.cfg[IDX_CTRL][CTRL_AUTO_BIT] && start_cnt < start_lim && !fire[F_STARTS]) begin
            st_next.flags[F_STARTS] = 1'b0;
        end
        if (start_lim == 3'h0) begin
            st_next.flags[F_STARTS] = 1'b0;
        end

        // axi read
        if (st_reg.rvalid && s_axi_rready_i) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            if (s_axi_araddr_i[7:2] < 6'(NCFG)) begin
                st_next.rdata = st_reg.cfg[s_axi_araddr_i[7:2]];
            end else if (s_axi_araddr_i[7:2] == IDX_STATUS) begin
                st_next.rdata[1:0] = st_reg.motor;
                st_next.rdata[STAT_FLAG_LSB +: NFLAG] = st_reg.flags;
                st_next.rdata[STAT_CNT_LSB +: 3] = start_cnt;
            end else if (s_axi_araddr_i[7:2] == IDX_UB_RATIO) begin
                st_next.rdata[15:0] = ub_ratio;
            end else if (s_axi_araddr_i[7:2] != IDX_CLEAR) begin
                st_next.rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
            st_reg.cfg <= CFG_RST;
            st_reg.motor <= MCP_STOPPED;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready_o = !st_reg.aw_got;
    assign s_axi_wready_o = !st_reg.w_got;
    assign s_axi_bvalid_o = st_reg.bvalid;
    assign s_axi_bresp_o = st_reg.bresp;
    assign s_axi_arready_o = !st_reg.rvalid;
    assign s_axi_rvalid_o = st_reg.rvalid;
    assign s_axi_rdata_o = st_reg.rdata;
    assign s_axi_rresp_o = st_reg.rresp;

    assign nv_starts_o = start_cnt;
    // bias path only, protection uses the ratio regardless
    assign ub_bias_o = st_reg.cfg[IDX_CTRL][CTRL_BIAS_BIT] ? ub_ratio : 16'h0000;
    assign motor_running_o = st_reg.motor == MCP_RUNNING;
    assign accel_trip_o = st_reg.flags[F_ACCEL];
    assign overload_trip_o = st_reg.flags[F_OL];
    assign starts_trip_o = st_reg.flags[F_STARTS];
    assign ub_trip_o = st_reg.flags[F_UBT];
    assign ub_alarm_o = st_reg.flags[F_UBA];
    assign single_phase_trip_o = st_reg.flags[F_SP];
    assign gf_trip_o = st_reg.flags[F_GFT];
    assign gf_alarm_o = st_reg.flags[F_GFA];
    assign uc_alarm_o = st_reg.flags[F_UC];
    assign jam_trip_o = st_reg.flags[F_JAM];
endmodule : mcp_protect

// ---- pkg/mcp_pkg.sv ----
package mcp_pkg;
    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned SP_DELAY_S = 4;
    localparam logic [15:0] SP_TICKS = 16'(SP_DELAY_S * 1000 / TICK_MS);
    localparam int unsigned MINUTE_S = 60;
    localparam logic [9:0] MIN_TICKS = 10'(MINUTE_S * 1000 / TICK_MS);
    localparam logic [5:0] HOUR_MIN = 6'h3c;
    localparam logic [15:0] GF_DLY_MAX = 16'h00c8;
    localparam logic [15:0] JAM_DLY_MIN = 16'h0005;
    localparam logic [15:0] JAM_DLY_MAX = 16'h04e2;

    // percentages
    localparam logic [31:0] STOP_PCT = 32'h0000_0005;
    localparam logic [31:0] SP_UB_PCT = 32'h0000_001e;
    localparam logic [31:0] SP_LOAD_PCT = 32'h0000_0019;
    localparam logic [31:0] FULL_PCT = 32'h0000_0064;
    localparam logic [15:0] JAM_PCT_MIN = 16'h0096;
    localparam logic [15:0] JAM_PCT_MAX = 16'h01c2;
    localparam logic [7:0] THERM_FULL = 8'h64;

    // ground ct ratio codes: 0 is 2000:1, k is (50*k):5 for k = 1..5
    localparam logic [2:0] GF_CT_2000 = 3'h0;
    localparam logic [2:0] GF_CT_MAX = 3'h5;
    localparam logic [31:0] GF_2000_MUL = 32'h0000_0014;
    localparam logic [31:0] GF_X5_DIV = 32'h0000_000a;

    // register word indices (byte address = 4 * index)
    localparam int unsigned NCFG = 11;
    localparam logic [5:0] IDX_RATED = 6'h00;
    localparam logic [5:0] IDX_CT_PRI = 6'h01;
    localparam logic [5:0] IDX_ACCEL = 6'h02;
    localparam logic [5:0] IDX_CTRL = 6'h03;
    localparam logic [5:0] IDX_UB_TRIP = 6'h04;
    localparam logic [5:0] IDX_UB_ALM = 6'h05;
    localparam logic [5:0] IDX_GF_TRIP = 6'h06;
    localparam logic [5:0] IDX_GF_ALM = 6'h07;
    localparam logic [5:0] IDX_UC = 6'h08;
    localparam logic [5:0] IDX_JAM = 6'h09;
    localparam logic [5:0] IDX_GF_CT = 6'h0a;
    localparam logic [5:0] IDX_STATUS = 6'h0b;
    localparam logic [5:0] IDX_UB_RATIO = 6'h0c;
    localparam logic [5:0] IDX_CLEAR = 6'h0d;

    // writable bits of each config word
    localparam logic [NCFG-1:0][31:0] CFG_MASK = {
        32'h0000_0007, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'h0000_0707, 32'h0000_ffff, 32'h0000_ffff};
    localparam logic [NCFG-1:0][31:0] CFG_RST = '0;

    // CTRL fields
    localparam int unsigned CTRL_LIM_LSB = 0;
    localparam int unsigned CTRL_AUTO_BIT = 8;
    localparam int unsigned CTRL_BIAS_BIT = 9;
    localparam int unsigned CTRL_UC_LATCH_BIT = 10;
    // level in [15:0], delay (0.1 s units) in [31:16]
    localparam int unsigned LVL_LSB = 0;
    localparam int unsigned DLY_LSB = 16;
    localparam int unsigned CLEAR_BIT = 0;

    // fault flags
    localparam int unsigned NFLAG = 10;
    localparam int unsigned F_ACCEL = 0;
    localparam int unsigned F_OL = 1;
    localparam int unsigned F_STARTS = 2;
    localparam int unsigned F_UBT = 3;
    localparam int unsigned F_UBA = 4;
    localparam int unsigned F_SP = 5;
    localparam int unsigned F_GFT = 6;
    localparam int unsigned F_GFA = 7;
    localparam int unsigned F_UC = 8;
    localparam int unsigned F_JAM = 9;
    localparam int unsigned STAT_FLAG_LSB = 2;
    localparam int unsigned STAT_CNT_LSB = 12;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MCP_STOPPED, MCP_STARTING, MCP_RUNNING} mcp_motor_e;
endpackage : mcp_pkg

// ---- dv/mcp_protect_checker.sv ----
`timescale 1ns/1ps
module mcp_protect_checker #(parameter int unsigned MAX_STARTS = 5) (
    input wire logic mclk_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic s_axi_awready_o, // write address ready
    input wire logic s_axi_bvalid_o, // write response valid
    input wire logic s_axi_bready_i, // write response ready
    input wire logic s_axi_arready_o, // read address ready
    input wire logic s_axi_rvalid_o, // read data valid
    input wire logic s_axi_rready_i, // read data ready
    input wire logic [31:0] s_axi_rdata_o, // read data
    input wire logic [7:0] thermal_used_i, // thermal capacity used
    input wire logic [2:0] nv_starts_o, // start count
    input wire logic motor_running_o, // running state
    input wire logic accel_trip_o, // acceleration fault
    input wire logic overload_trip_o, // overload trip
    input wire logic starts_trip_o, // starts trip
    input wire logic jam_trip_o // jam trip
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    ol_trip_set_a: assert property (thermal_used_i >= 8'h64 |=> overload_trip_o) else $error("overload late");
    starts_stopped_a: assert property ($rose(starts_trip_o) |-> !motor_running_o) else $error("starts trip run");
    accel_no_run_a: assert property ($rose(accel_trip_o) |-> !$past(motor_running_o)) else $error("accel trip run");
    jam_after_run_a: assert property ($rose(jam_trip_o) |-> $past(motor_running_o)) else $error("jam early");
    count_limit_a: assert property (nv_starts_o <= 3'(MAX_STARTS)) else $error("start count high");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid drop");
    r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("rvalid drop");
    ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("arready with rvalid");
    b_after_aw_a: assert property ($rose(s_axi_bvalid_o) |-> !$past(s_axi_awready_o)) else $error("bvalid early");
    cover property (starts_trip_o);
    cover property (jam_trip_o);
    cover property (accel_trip_o);
endmodule : mcp_protect_checker
bind mcp_protect mcp_protect_checker #(.MAX_STARTS(MAX_STARTS)) chk_u (.*);

// ---- dv/mcp_sense_model.sv ----
`timescale 1ns/1ps
// three-phase sensing, balanced unless phase c is open
module mcp_sense_model (
    input wire logic [15:0] load_i, // commanded current, 0.1 A
    input wire logic phase_loss_i, // phase c open
    output logic [15:0] ia_o, // phase a
    output logic [15:0] ib_o, // phase b
    output logic [15:0] ic_o, // phase c
    output logic [15:0] neg_o, // negative sequence
    output logic [15:0] pos_o // positive sequence
);
    assign {ia_o, ib_o, pos_o} = {3{load_i}};
    assign ic_o = phase_loss_i ? 16'h0000 : load_i;
    // an open phase puts as much current in negative as in positive sequence
    assign neg_o = phase_loss_i ? load_i : 16'h0000;
endmodule : mcp_sense_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import mcp_pkg::*;
    logic mclk_i = 0, nrst_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, lost = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, motor_running_o, accel_trip_o, overload_trip_o, starts_trip_o;
    logic ub_trip_o, ub_alarm_o, single_phase_trip_o, gf_trip_o, gf_alarm_o, uc_alarm_o, jam_trip_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [2:0] nv_starts_i = '0, nv_starts_o;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, thermal_used_i = '0;
    logic [15:0] load = '0, ia_i, ib_i, ic_i, neg_seq_i, pos_seq_i, gnd_sec_i = '0, ub_bias_o;
    logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
    logic [10:0] fl;
    int num_errors = 0, checked = 0;
    assign fl = {motor_running_o, jam_trip_o, uc_alarm_o, gf_alarm_o, gf_trip_o, single_phase_trip_o,
        ub_alarm_o, ub_trip_o, starts_trip_o, overload_trip_o, accel_trip_o};
    initial forever #50 mclk_i = ~mclk_i;
    mcp_sense_model sm_u (.load_i(load), .phase_loss_i(lost), .ia_o(ia_i), .ib_o(ib_i), .ic_o(ic_i),
        .neg_o(neg_seq_i), .pos_o(pos_seq_i));
    mcp_protect #(.TICK_CYCLES(10)) dut_u (.*);
    task automatic finish_test(bit hung);
        num_errors += hung;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = RESP_OKAY);
        logic pa = 1, pw = 1, pb = 1;
        logic [1:0] r;
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        for (int i = 0; i < 50 && pb; i++) begin
            #1;
            pa = pa & !s_axi_awready_o;
            pw = pw & !s_axi_wready_o;
            pb = !s_axi_bvalid_o;
            r = s_axi_bresp_o;
            @(posedge mclk_i);
            {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {pa, pw, pb};
        end
        if (pb) finish_test(1);
        chk("write resp", 32'(er), 32'(r));
    endtask : wr
    task automatic rc(string n, logic [7:0] a, logic [31:0] e, logic [1:0] er);
        logic pa = 1, pr = 1;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        for (int i = 0; i < 50 && pr; i++) begin
            #1;
            pa = pa & !s_axi_arready_o;
            pr = !s_axi_rvalid_o;
            {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
            @(posedge mclk_i);
            {s_axi_arvalid_i, s_axi_rready_i} <= {pa, pr};
        end
        if (pr) finish_test(1);
        chk(n, e, d);
        chk({n, " resp"}, 32'(er), 32'(r));
    endtask : rc
    // bounded wait for one flag; running out ends the run
    // looks just after the edge, returns on an edge so the next stimulus lands there
    task automatic wf(int b, logic e);
        int i;
        for (i = 0; i < 1000 && fl[b] !== e; i++) begin
            @(posedge mclk_i);
            #1;
        end
        chk($sformatf("flag %0d", b), 32'(e), 32'(fl[b]));
        if (i == 1000) finish_test(1);
        @(posedge mclk_i);
    endtask : wf
    task automatic t_reset();
        rc("status", 8'h2c, 32'h0, RESP_OKAY);
        rc("unmapped", 8'hfc, 32'h0, RESP_SLVERR);
        wr(8'hfc, 32'h0, RESP_SLVERR);
        $display("reset test done");
    endtask : t_reset
    task automatic t_start();
        wr(8'h00, 32'h64);
        wr(8'h04, 32'h64);
        wr(8'h08, 32'h3);
        wr(8'h0c, 32'h1);
        wr(8'h24, 32'h0005_0096);
        rc("jam setting", 8'h24, 32'h0005_0096, RESP_OKAY);
        load <= 16'h012c;
        wf(F_ACCEL, 1);
        rc("status", 8'h2c, 32'h0000_1005, RESP_OKAY);
        load <= 16'h0050;
        wf(10, 1);
        load <= 16'h00c8;
        wf(F_JAM, 1);
        chk("starts while running", 32'h0, 32'(starts_trip_o));
        load <= 16'h0000;
        wf(10, 0);
        wf(F_STARTS, 1);
        chk("saved starts", 32'h1, 32'(nv_starts_o));
        $display("start test done");
    endtask : t_start
    task automatic t_faults();
        thermal_used_i <= 8'h64;
        wf(F_OL, 1);
        wr(8'h28, 32'h1);
        wr(8'h18, 32'h0000_000a);
        wr(8'h1c, 32'h0000_000a);
        gnd_sec_i <= 16'h0064;
        repeat (20) @(posedge mclk_i);
        #1;
        chk("ground at 50:5", 32'h0, 32'(gf_alarm_o));
        wr(8'h28, 32'h0);
        wf(F_GFT, 1);
        wf(F_GFA, 1);
        $display("fault test done");
    endtask : t_faults
    task automatic t_unbal();
        wr(8'h0c, 32'h200);
        wf(F_STARTS, 0);
        wr(8'h10, 32'h0002_0014);
        wr(8'h14, 32'h14);
        wr(8'h20, 32'h50);
        load <= 16'h00c8;
        lost <= 1;
        wf(F_UBA, 1);
        wf(F_UBT, 1);
        rc("unbalance", 8'h30, 32'h64, RESP_OKAY);
        chk("bias", 32'h64, 32'(ub_bias_o));
        wf(F_SP, 1);
        lost <= 0;
        wf(F_UBA, 0);
        load <= 16'h003c;
        wf(F_UC, 1);
        load <= 16'h0000;
        wf(F_UC, 0);
        $display("unbalance test done");
    endtask : t_unbal
    initial begin
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1;
        t_reset();
        t_start();
        t_faults();
        t_unbal();
        finish_test(0);
    end
endmodule : testbench
